/* File: hw/osc_ctrl.v */
// Oscillator group switch control, clock-fail flag, RC trim sequencer
// and pseudo-random trim register behind an Avalon-MM slave.
// Assumes one clock, inputs synchronous to it, analog parts outside.
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "osc_ctrl_defines.vh"

module osc_ctrl #(
  parameter DITHER_DIV = 1
) (
  // Clock and reset
  input  wire        CLK,
  input  wire        RST_N,
  // Avalon-MM slave
  input  wire [2:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [15:0] AVS_WRITEDATA,
  input  wire [1:0]  AVS_BYTEENABLE,
  output wire [15:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  // Configuration settings
  input  wire [1:0]  CFG_INIT_GROUP,
  input  wire [1:0]  CFG_SWITCH_MON,
  // Clock system status
  input  wire        PLL_LOCKED,
  input  wire        FAIL_DETECT,
  input  wire        SWITCH_DONE,
  input  wire [2:0]  PWM_ROLL,
  // Clock system control
  output wire [2:0]  CURRENT_GROUP,
  output wire [2:0]  TARGET_GROUP,
  output wire        SWITCH_START,
  output wire        SWITCH_BUSY,
  output wire        MONITOR_ENABLE,
  output wire [3:0]  TRIM_OUT,
  output wire        DITHER_ON,
  output wire [14:0] DITHER_VALUE
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // ****************************************
  // Functions
  // ****************************************
  function [1:0] unlk_next;
    input [1:0] st;
    input       wr_lane;
    input [7:0] d;
    input [7:0] k1;
    input [7:0] k2;
    begin
      case (st)
        `UNLK_IDLE: begin
          unlk_next = (wr_lane && d == k1) ? `UNLK_KEY1 : `UNLK_IDLE;
        end
        `UNLK_KEY1: begin
          // Repeating the first key keeps the sequence armed
          if (wr_lane && d == k2) begin
            unlk_next = `UNLK_OPEN;
          end else if (wr_lane && d == k1) begin
            unlk_next = `UNLK_KEY1;
          end else begin
            unlk_next = `UNLK_IDLE;
          end
        end
        default: begin
          unlk_next = `UNLK_IDLE;
        end
      endcase
    end
  endfunction

  function is_pll;
    input [2:0] g;
    begin
      is_pll = (g == `GRP_RC_PLL) || (g == `GRP_PRI_PLL);
    end
  endfunction

  function [3:0] nib;
    input [15:0] w;
    input [1:0]  i;
    begin
      nib = w[i*`NIB_W +: `NIB_W];
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg        ack_reg;
  reg [15:0] rdata_reg;
  reg [1:0]  unlk_lo_reg;
  reg [1:0]  unlk_hi_reg;
  reg [2:0]  cur_reg;
  reg [2:0]  req_reg;
  reg        freeze_reg;
  reg        lock_reg;
  reg        pll_prev_reg;
  reg        dith_reg;
  reg        cf_reg;
  reg        seqen_reg;
  reg        swreq_reg;
  reg        state_reg;
  reg        start_reg;
  reg [15:0] trim_lo_reg;
  reg [15:0] trim_hi_reg;
  reg [14:0] pseudo_random_trim_reg;
  reg [15:0] div_reg;
  reg [3:0]  trim_reg;
  reg [3:0]  trim_next;

  // ****************************************
  // Bus decode
  // ****************************************
  // One wait state on every access keeps read data registered
  wire req = AVS_READ | AVS_WRITE;
  wire acc = req & ack_reg;
  wire wr  = acc & AVS_WRITE;
  wire wr_ctrl = wr && AVS_ADDRESS == `IDX_CTRL;
  wire lo_only = wr_ctrl && AVS_BYTEENABLE == `BE_LO;
  wire hi_only = wr_ctrl && AVS_BYTEENABLE == `BE_HI;
  wire [7:0] wd_lo = AVS_WRITEDATA[7:0];
  wire [7:0] wd_hi = AVS_WRITEDATA[15:8];
  wire lo_ok = lo_only && unlk_lo_reg == `UNLK_OPEN;
  wire hi_ok = hi_only && unlk_hi_reg == `UNLK_OPEN;
  wire wr_trlo = wr && AVS_ADDRESS == `IDX_TRIM_LO;
  wire wr_trhi = wr && AVS_ADDRESS == `IDX_TRIM_HI;
  wire wr_dith = wr && AVS_ADDRESS == `IDX_DITHER;

  // ****************************************
  // Switch qualification
  // ****************************************
  wire sw_dis   = CFG_SWITCH_MON[`CFG_SWDIS];
  wire frozen   = freeze_reg & sw_dis;
  wire fs_on    = CFG_SWITCH_MON == `CFG_FS_ON;
  wire fail_ev  = FAIL_DETECT & fs_on;
  // Reserved codes are refused only at the start of a switch
  wire rsv      = req_reg[`GRP_RSV_BIT];
  wire sw_go    = swreq_reg && state_reg == ST_IDLE && !fail_ev;
  wire sw_valid = sw_go && !sw_dis && !rsv && req_reg != cur_reg;
  wire sw_drop  = sw_go && !sw_valid;
  wire sw_end   = state_reg == ST_WAIT && SWITCH_DONE && !fail_ev;
  wire lock_rd  = lock_reg & is_pll(cur_reg);
  wire pll_rise = PLL_LOCKED & ~pll_prev_reg;
  wire step     = dith_reg && div_reg == DITHER_DIV - 1;
  wire fb = pseudo_random_trim_reg[`PSEUDO_RANDOM_TRIM_TAP_A] ^ pseudo_random_trim_reg[`PSEUDO_RANDOM_TRIM_TAP_B]
            ^ (pseudo_random_trim_reg == `PSEUDO_RANDOM_TRIM_RST);

  wire [15:0] ctrl_rd = {1'b0, cur_reg, 1'b0, req_reg,
                         freeze_reg, 1'b0, lock_rd, dith_reg,
                         cf_reg, seqen_reg, 1'b0, swreq_reg};

  // ****************************************
  // Bus handshake and read data
  // ****************************************
  always @(posedge CLK) begin
    if (!RST_N) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (AVS_READ && !ack_reg) begin
        case (AVS_ADDRESS)
          `IDX_CTRL:    rdata_reg <= ctrl_rd;
          `IDX_TRIM_LO: rdata_reg <= trim_lo_reg;
          `IDX_TRIM_HI: rdata_reg <= trim_hi_reg;
          `IDX_DITHER:  rdata_reg <= {1'b0, pseudo_random_trim_reg};
          default:      rdata_reg <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************
  // Unlock sequencers
  // ****************************************
  // Any completed access counts as an intervening instruction
  always @(posedge CLK) begin
    if (!RST_N) begin
      unlk_lo_reg <= `UNLK_IDLE;
      unlk_hi_reg <= `UNLK_IDLE;
    end else if (acc) begin
      unlk_lo_reg <= unlk_next(unlk_lo_reg, lo_only, wd_lo,
                               `KEY_LO_1, `KEY_LO_2);
      unlk_hi_reg <= unlk_next(unlk_hi_reg, hi_only, wd_hi,
                               `KEY_HI_1, `KEY_HI_2);
    end
  end

  // ****************************************
  // Control register and switch sequence
  // ****************************************
  always @(posedge CLK) begin
    if (!RST_N) begin
      cur_reg      <= `GRP_RC;
      req_reg      <= {1'b0, CFG_INIT_GROUP};
      freeze_reg   <= 1'b0;
      lock_reg     <= 1'b0;
      pll_prev_reg <= 1'b0;
      dith_reg     <= 1'b0;
      cf_reg       <= 1'b0;
      seqen_reg    <= 1'b0;
      swreq_reg    <= 1'b0;
      state_reg    <= ST_IDLE;
      start_reg    <= 1'b0;
    end else begin
      pll_prev_reg <= PLL_LOCKED;
      start_reg    <= sw_valid;
      // Low byte, only inside an open window
      if (lo_ok) begin
        if (wd_lo[`B_FREEZE]) begin
          freeze_reg <= 1'b1;
        end
        dith_reg  <= wd_lo[`B_DITH];
        seqen_reg <= wd_lo[`B_SEQEN];
        if (wd_lo[`B_SWREQ] && !frozen) begin
          swreq_reg <= 1'b1;
        end
      end
      // High byte, only inside an open window
      if (hi_ok && !frozen) begin
        req_reg <= wd_hi[`F_REQ_MSB-8:`F_REQ_LSB-8];
      end
      // Fail flag: software clears with 0, hardware set wins
      if (fail_ev) begin
        cf_reg <= 1'b1;
      end else if (sw_valid) begin
        cf_reg <= 1'b0;
      end else if (lo_ok && !wd_lo[`B_CF]) begin
        cf_reg <= 1'b0;
      end
      // Lock status follows the PLL
      // A PLL still locked across a switch waits for a fresh rise
      if (sw_valid || !PLL_LOCKED) begin
        lock_reg <= 1'b0;
      end else if (pll_rise) begin
        lock_reg <= 1'b1;
      end
      // Switch sequence; fallback overrides everything
      if (fail_ev) begin
        cur_reg   <= `GRP_RC;
        swreq_reg <= 1'b0;
        state_reg <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (sw_valid) begin
              state_reg <= ST_WAIT;
            end else if (sw_drop) begin
              swreq_reg <= 1'b0;
            end
          end
          ST_WAIT: begin
            if (sw_end) begin
              cur_reg   <= req_reg;
              swreq_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Trim registers and applied trim
  // ****************************************
  // Registered after the mux so a roll change cannot glitch the trim
  always @* begin
    trim_next = nib(trim_lo_reg, 2'h0);
    if (seqen_reg) begin
      case (PWM_ROLL)
        3'h1: trim_next = nib(trim_lo_reg, 2'h1);
        3'h2: trim_next = nib(trim_lo_reg, 2'h2);
        3'h3: trim_next = nib(trim_lo_reg, 2'h3);
        3'h4: trim_next = nib(trim_hi_reg, 2'h0);
        3'h5: trim_next = nib(trim_hi_reg, 2'h1);
        3'h6: trim_next = nib(trim_hi_reg, 2'h2);
        3'h7: trim_next = nib(trim_hi_reg, 2'h3);
        default: trim_next = nib(trim_lo_reg, 2'h0);
      endcase
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      trim_lo_reg <= `TRIM_RST;
      trim_hi_reg <= `TRIM_RST;
      trim_reg    <= `TRIM_OUT_RST;
    end else begin
      // Signed code passes to the oscillator unchanged
      trim_reg <= trim_next;
      if (wr_trlo) begin
        if (AVS_BYTEENABLE[0]) trim_lo_reg[7:0]  <= wd_lo;
        if (AVS_BYTEENABLE[1]) trim_lo_reg[15:8] <= wd_hi;
      end
      if (wr_trhi) begin
        if (AVS_BYTEENABLE[0]) trim_hi_reg[7:0]  <= wd_lo;
        if (AVS_BYTEENABLE[1]) trim_hi_reg[15:8] <= wd_hi;
      end
    end
  end

  // ****************************************
  // Pseudo-random dither register
  // ****************************************
  // Zero state would lock up, so the feedback injects a one there
  // Divider is 16 bits, so DITHER_DIV must stay at or below 65536
  always @(posedge CLK) begin
    if (!RST_N) begin
      pseudo_random_trim_reg <= `PSEUDO_RANDOM_TRIM_RST;
      div_reg  <= 16'h0000;
    end else begin
      if (!dith_reg || step) begin
        div_reg <= 16'h0000;
      end else begin
        div_reg <= div_reg + 16'h0001;
      end
      if (wr_dith) begin
        if (AVS_BYTEENABLE[0]) pseudo_random_trim_reg[7:0] <= wd_lo;
        if (AVS_BYTEENABLE[1]) begin
          pseudo_random_trim_reg[`PSEUDO_RANDOM_TRIM_MSB:8] <= wd_hi[6:0];
        end
      end else if (step) begin
        pseudo_random_trim_reg <= {pseudo_random_trim_reg[`PSEUDO_RANDOM_TRIM_MSB-1:0], fb};
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign AVS_READDATA    = rdata_reg;
  assign CURRENT_GROUP   = cur_reg;
  assign TARGET_GROUP    = req_reg;
  assign SWITCH_START    = start_reg;
  // Busy is the wait state itself, so it cannot lag the sequence
  assign SWITCH_BUSY     = state_reg;
  assign MONITOR_ENABLE  = fs_on;
  assign TRIM_OUT        = trim_reg;
  assign DITHER_ON       = dith_reg;
  assign DITHER_VALUE    = pseudo_random_trim_reg;

endmodule // osc_ctrl

/* File: hw/osc_ctrl_defines.vh */
// Offsets, fields, keys and reset values of the oscillator control block.
// Assumes inclusion by bare name from the design file.
`ifndef OSC_CTRL_DEFINES_VH
`define OSC_CTRL_DEFINES_VH
// ****************************************
// Register indices (word address)
// ****************************************
`define IDX_CTRL      3'h0
`define IDX_TRIM_LO   3'h1
`define IDX_TRIM_HI   3'h2
`define IDX_DITHER    3'h3
// ****************************************
// Byte lanes and unlock keys
// ****************************************
`define BE_LO         2'h1
`define BE_HI         2'h2
`define KEY_LO_1      8'h46
`define KEY_LO_2      8'h57
`define KEY_HI_1      8'h78
`define KEY_HI_2      8'h9a
`define UNLK_IDLE     2'h0
`define UNLK_KEY1     2'h1
`define UNLK_OPEN     2'h2
// ****************************************
// Control register fields
// ****************************************
`define B_SWREQ       0
`define B_SEQEN       2
`define B_CF          3
`define B_DITH        4
`define B_LOCK        5
`define B_FREEZE      7
`define F_REQ_LSB     8
`define F_REQ_MSB     10
`define F_CUR_LSB     12
`define F_CUR_MSB     14
// ****************************************
// Group codes and configuration
// ****************************************
`define GRP_RC        3'h0
`define GRP_RC_PLL    3'h1
`define GRP_PRI_PLL   3'h3
`define GRP_RSV_BIT   2
`define CFG_SWDIS     1
`define CFG_FS_ON     2'h0
// ****************************************
// Reset values and dither taps
// ****************************************
`define TRIM_RST      16'h0000
`define TRIM_OUT_RST  4'h0
`define PSEUDO_RANDOM_TRIM_RST      15'h0000
`define PSEUDO_RANDOM_TRIM_TAP_A    14
`define PSEUDO_RANDOM_TRIM_TAP_B    13
`define PSEUDO_RANDOM_TRIM_MSB      14
`define NIB_W         4
`endif

/* File: tb/osc_ctrl_assertions.sv */
// Port checker for the oscillator control block.
// Assumes a bind onto osc_ctrl; one clock, sync active-low reset.
`timescale 1ns/1ps
module osc_ctrl_assertions #(
  parameter DITHER_DIV = 1
) (
  // Clock, reset and bus
  input wire        CLK,
  input wire        RST_N,
  input wire        AVS_WRITE,
  // Configuration and status
  input wire [1:0]  CFG_SWITCH_MON,
  input wire        FAIL_DETECT,
  input wire        SWITCH_DONE,
  // Outputs watched
  input wire [2:0]  CURRENT_GROUP,
  input wire [2:0]  TARGET_GROUP,
  input wire        SWITCH_START,
  input wire        SWITCH_BUSY,
  input wire        MONITOR_ENABLE,
  input wire        DITHER_ON,
  input wire [14:0] DITHER_VALUE
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_CUR_RSV: assert property (!CURRENT_GROUP[2])
    else $error("reserved current group");
  AST_FAIL_RC: assert property (FAIL_DETECT && CFG_SWITCH_MON == 2'h0
    |=> CURRENT_GROUP == 3'h0) else $error("no fallback on fail");
  AST_DONE_LOAD: assert property (SWITCH_BUSY && SWITCH_DONE
    && !FAIL_DETECT |=> CURRENT_GROUP == $past(TARGET_GROUP))
    else $error("switch did not load group");
  AST_CUR_HOLD: assert property (!SWITCH_DONE && !FAIL_DETECT
    |=> $stable(CURRENT_GROUP)) else $error("group changed unasked");
  AST_SW_DIS: assert property (CFG_SWITCH_MON[1]
    && $past(CFG_SWITCH_MON[1]) |-> !SWITCH_START)
    else $error("switch started while disabled");
  AST_START_PULSE: assert property (SWITCH_START
    |-> SWITCH_BUSY ##1 !SWITCH_START) else $error("bad start pulse");
  AST_MON: assert property (MONITOR_ENABLE == (CFG_SWITCH_MON == 2'h0))
    else $error("monitor enable wrong");
  AST_DITH_HOLD: assert property (!DITHER_ON && !AVS_WRITE
    |=> $stable(DITHER_VALUE)) else $error("dither moved while off");
  AST_DITH_RUN: assert property (DITHER_ON && !AVS_WRITE
    && DITHER_DIV == 1 |=> DITHER_VALUE != 15'h0000)
    else $error("dither stuck at zero");
endmodule // osc_ctrl_assertions

/* File: tb/tb.sv */
// Self-checking bench for the oscillator control block.
// Assumes osc_ctrl under hw/ and its checker under tb/.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %h want %h", $time, (g), (e)); end end
module tb;
  // ********
  // Signals
  // ********
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [2:0]  AVS_ADDRESS = 3'h0;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [15:0] AVS_WRITEDATA = 16'h0000;
  logic [1:0]  AVS_BYTEENABLE = 2'h0;
  logic [1:0]  CFG_INIT_GROUP = 2'h2;
  logic [1:0]  CFG_SWITCH_MON = 2'h0;
  logic        PLL_LOCKED = 1'b0;
  logic        FAIL_DETECT = 1'b0;
  logic        SWITCH_DONE = 1'b0;
  logic [2:0]  PWM_ROLL = 3'h0;
  wire  [15:0] AVS_READDATA;
  wire         AVS_WAITREQUEST;
  wire  [2:0]  CURRENT_GROUP;
  wire  [2:0]  TARGET_GROUP;
  wire         SWITCH_START;
  wire         SWITCH_BUSY;
  wire         MONITOR_ENABLE;
  wire  [3:0]  TRIM_OUT;
  wire         DITHER_ON;
  wire  [14:0] DITHER_VALUE;
  int          bad_count = 0;
  int          compares = 0;
  int          starts = 0;
  logic [15:0] q;
  // Rows: sequencer enable, roll index, expected trim
  logic [7:0]  rows [9] = '{8'h01, 8'h81, 8'h92, 8'ha3, 8'hb4, 8'hc5,
                            8'hd6, 8'he7, 8'hf8};
  osc_ctrl #(
    .DITHER_DIV(1)
  ) osc_ctrl_i (
    .CLK             (CLK),
    .RST_N           (RST_N),
    .AVS_ADDRESS     (AVS_ADDRESS),
    .AVS_READ        (AVS_READ),
    .AVS_WRITE       (AVS_WRITE),
    .AVS_WRITEDATA   (AVS_WRITEDATA),
    .AVS_BYTEENABLE  (AVS_BYTEENABLE),
    .AVS_READDATA    (AVS_READDATA),
    .AVS_WAITREQUEST (AVS_WAITREQUEST),
    .CFG_INIT_GROUP  (CFG_INIT_GROUP),
    .CFG_SWITCH_MON  (CFG_SWITCH_MON),
    .PLL_LOCKED      (PLL_LOCKED),
    .FAIL_DETECT     (FAIL_DETECT),
    .SWITCH_DONE     (SWITCH_DONE),
    .PWM_ROLL        (PWM_ROLL),
    .CURRENT_GROUP   (CURRENT_GROUP),
    .TARGET_GROUP    (TARGET_GROUP),
    .SWITCH_START    (SWITCH_START),
    .SWITCH_BUSY     (SWITCH_BUSY),
    .MONITOR_ENABLE  (MONITOR_ENABLE),
    .TRIM_OUT        (TRIM_OUT),
    .DITHER_ON       (DITHER_ON),
    .DITHER_VALUE    (DITHER_VALUE)
  );
  always #2.5 CLK = ~CLK;
  always @(posedge CLK) if (SWITCH_START === 1'b1) starts <= starts + 1;
  // ********
  // Tasks
  // ********
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input [2:0] a, input w, input [1:0] be,
                     input [15:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_READ <= !w;
    AVS_WRITE <= w;
    AVS_BYTEENABLE <= be;
    AVS_WRITEDATA <= d;
    // Hold everything until waitrequest is seen low at a rising edge
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
    if (AVS_WAITREQUEST !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic rd(input [2:0] a);
    bus(a, 1'b0, 2'h3, 16'h0000);
  endtask
  task automatic wlo(input [7:0] d);
    bus(3'h0, 1'b1, 2'h1, 16'h0046);
    bus(3'h0, 1'b1, 2'h1, 16'h0057);
    bus(3'h0, 1'b1, 2'h1, {8'h00, d});
  endtask
  task automatic whi(input [7:0] d);
    bus(3'h0, 1'b1, 2'h2, 16'h7800);
    bus(3'h0, 1'b1, 2'h2, 16'h9a00);
    bus(3'h0, 1'b1, 2'h2, {d, 8'h00});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic sw_ok(input [7:0] g);
    int n;
    whi(g);
    wlo(8'h01);
    n = 0;
    while (SWITCH_BUSY !== 1'b1 && n < 20) begin
      @(negedge CLK);
      n++;
    end
    if (SWITCH_BUSY !== 1'b1) begin
      bad_count++;
      give_verdict();
    end
    // Lock comes up before the mux reports completion
    @(posedge CLK);
    PLL_LOCKED <= 1'b1;
    @(posedge CLK);
    SWITCH_DONE <= 1'b1;
    @(posedge CLK);
    SWITCH_DONE <= 1'b0;
    idle(2);
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    repeat (50000) @(posedge CLK);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    rd(3'h0);
    `CHK(q, 16'h0200)
    `CHK(CURRENT_GROUP, 3'h0)
    for (int a = 1; a < 6; a++) begin
      rd(a[2:0]);
      `CHK(q, 16'h0000)
    end
    bus(3'h1, 1'b1, 2'h3, 16'h4321);
    bus(3'h2, 1'b1, 2'h3, 16'h8765);
    rd(3'h2);
    `CHK(q, 16'h8765)
    foreach (rows[i]) begin
      if (rows[i][7]) wlo(8'h04);
      PWM_ROLL <= rows[i][6:4];
      idle(3);
      `CHK(TRIM_OUT, rows[i][3:0])
    end
    wlo(8'h00);
    idle(3);
    `CHK(TRIM_OUT, 4'h1)
    // Keyless, broken key, spent window, unimplemented bits
    bus(3'h0, 1'b1, 2'h3, 16'hffff);
    bus(3'h0, 1'b1, 2'h1, 16'h0046);
    rd(3'h1);
    bus(3'h0, 1'b1, 2'h1, 16'h0057);
    bus(3'h0, 1'b1, 2'h1, 16'h0001);
    rd(3'h0);
    `CHK(q, 16'h0200)
    wlo(8'h42);
    bus(3'h0, 1'b1, 2'h1, 16'h0010);
    whi(8'h88);
    rd(3'h0);
    `CHK(q, 16'h0000)
    wlo(8'h10);
    idle(5);
    `CHK(DITHER_ON, 1'b1)
    rd(3'h3);
    `CHK(q != 16'h0000, 1'b1)
    wlo(8'h00);
    bus(3'h3, 1'b1, 2'h3, 16'hffff);
    rd(3'h3);
    `CHK(q, 16'h7fff)
    `CHK(DITHER_VALUE, 15'h7fff)
    // Switching
    sw_ok(8'h03);
    rd(3'h0);
    `CHK(q, 16'h3320)
    @(posedge CLK);
    PLL_LOCKED <= 1'b0;
    idle(2);
    rd(3'h0);
    `CHK(q, 16'h3300)
    wlo(8'h01);
    idle(4);
    rd(3'h0);
    `CHK(q, 16'h3300)
    whi(8'h05);
    wlo(8'h01);
    idle(4);
    rd(3'h0);
    `CHK(q, 16'h3500)
    `CHK(TARGET_GROUP, 3'h5)
    sw_ok(8'h02);
    rd(3'h0);
    `CHK(q, 16'h2200)
    // Monitor fallback and flag
    CFG_SWITCH_MON <= 2'h1;
    FAIL_DETECT <= 1'b1;
    @(posedge CLK);
    FAIL_DETECT <= 1'b0;
    idle(2);
    `CHK(CURRENT_GROUP, 3'h2)
    `CHK(MONITOR_ENABLE, 1'b0)
    @(posedge CLK);
    CFG_SWITCH_MON <= 2'h0;
    FAIL_DETECT <= 1'b1;
    @(posedge CLK);
    FAIL_DETECT <= 1'b0;
    idle(2);
    rd(3'h0);
    `CHK(q, 16'h0208)
    wlo(8'h00);
    rd(3'h0);
    `CHK(q, 16'h0200)
    // Switching disabled, then frozen
    CFG_SWITCH_MON <= 2'h2;
    whi(8'h03);
    wlo(8'h01);
    idle(4);
    rd(3'h0);
    `CHK(q, 16'h0300)
    wlo(8'h80);
    wlo(8'h00);
    whi(8'h01);
    rd(3'h0);
    `CHK(q, 16'h0380)
    `CHK(starts, 2)
    // Second reset mid-run clears the freeze
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd(3'h0);
    `CHK(q, 16'h0200)
    give_verdict();
  end
endmodule // tb
bind osc_ctrl osc_ctrl_assertions #(
  .DITHER_DIV(DITHER_DIV)
) osc_ctrl_assertions_i (
  .CLK            (CLK),
  .RST_N          (RST_N),
  .AVS_WRITE      (AVS_WRITE),
  .CFG_SWITCH_MON (CFG_SWITCH_MON),
  .FAIL_DETECT    (FAIL_DETECT),
  .SWITCH_DONE    (SWITCH_DONE),
  .CURRENT_GROUP  (CURRENT_GROUP),
  .TARGET_GROUP   (TARGET_GROUP),
  .SWITCH_START   (SWITCH_START),
  .SWITCH_BUSY    (SWITCH_BUSY),
  .MONITOR_ENABLE (MONITOR_ENABLE),
  .DITHER_ON      (DITHER_ON),
  .DITHER_VALUE   (DITHER_VALUE)
);
